/* rtl/tm_defines.svh */
// Named constants for the cascadable timer: mode codes, source selects,
// byte values and channel indices.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef TM_DEFINES_SVH
`define TM_DEFINES_SVH

// ==========================================================================
// Mode field codes
`define TM_MODE_PDO    3'h1
`define TM_MODE_PWM8   3'h2
`define TM_MODE_LOW16  3'h3
`define TM_MODE_TIM16  3'h4
`define TM_MODE_PWM16  3'h6

// ==========================================================================
// Source selects, values and indices
`define TM_SEL_PIN     3'h7
`define TM_BYTE_ZERO   8'h00
`define TM_BYTE_ONE    8'h01
`define TM_BYTE_MAX    8'hff
`define TM_WORD_ZERO   16'h0000
`define TM_WORD_ONE    16'h0001
`define TM_WORD_MAX    16'hffff
`define TM_FLOP_RST    1'b0
`define TM_PIN_IDLE    1'b1
`define TM_LO          0
`define TM_HI          1

`endif

/* rtl/tm_pkg.sv */
// Types shared by the cascadable timer files.
// Assumes nothing of its surroundings.
package tm_pkg;

  // ========================================================================
  // Operating mode of one counter after decode
  typedef enum logic [2:0] {
    TM_OP_IDLE,
    TM_OP_PDO,
    TM_OP_PWM8,
    TM_OP_TIM16,
    TM_OP_PWM16
  } tm_op_t;

  typedef logic [7:0] tm_byte_t;

endpackage

/* rtl/tm_tick_sel.sv */
// Source clock selection for one counter: internal taps or count pin.
// Assumes taps are one-cycle enables from a prescaler, synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "tm_defines.svh"

module tm_tick_sel (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  // Sources
  input  wire logic [6:0] tap_in,
  input  wire logic       pin_in,
  input  wire logic [2:0] sel_in,
  // Selected count enable
  output logic            tick_out
);

  // ========================================================================
  // Pin edge detect
  logic pin_prev_reg;
  logic pin_prev_next;
  logic pin_fall;

  always_comb begin
    pin_prev_next = pin_in;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_prev_reg <= `TM_PIN_IDLE;
    end else begin
      pin_prev_reg <= pin_prev_next;
    end
  end

  // Reset to the idle high level, so an idle pin gives no edge after reset
  assign pin_fall = pin_prev_reg & ~pin_in;

  always_comb begin
    if (sel_in == `TM_SEL_PIN) begin
      tick_out = pin_fall;
    end else begin
      tick_out = tap_in[sel_in];
    end
  end

  a_pin_fall_only: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    (sel_in == `TM_SEL_PIN && tick_out) |-> ($past(pin_in) && !pin_in))
    else $error("pin tick without falling edge");

endmodule
`default_nettype wire

/* rtl/tm_cascade_timer.sv */
// Two cascadable 8-bit up-counters: 8-bit divider and PWM, 16-bit timer,
// event counter and PWM.
// Assumes control inputs are register write strobes synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "tm_defines.svh"

module tm_cascade_timer (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  // Lower control write
  input  wire logic       lower_ctrl_wr_in,
  input  wire logic [2:0] lower_mode_in,
  input  wire logic [2:0] lower_clk_sel_in,
  input  wire logic       lower_run_bit_in,
  input  wire logic       lower_flop_init_bit_in,
  // Lower compare and duty writes
  input  wire logic       lower_compare_wr_in,
  input  wire logic [7:0] lower_compare_in,
  input  wire logic       lower_duty_wr_in,
  input  wire logic [7:0] lower_duty_in,
  // Lower clock sources
  input  wire logic [6:0] lower_tap_in,
  input  wire logic       lower_count_pin_in,
  // Upper control write
  input  wire logic       upper_ctrl_wr_in,
  input  wire logic [2:0] upper_mode_in,
  input  wire logic [2:0] upper_clk_sel_in,
  input  wire logic       upper_run_bit_in,
  input  wire logic       upper_flop_init_bit_in,
  // Upper compare and duty writes
  input  wire logic       upper_compare_wr_in,
  input  wire logic [7:0] upper_compare_in,
  input  wire logic       upper_duty_wr_in,
  input  wire logic [7:0] upper_duty_in,
  // Upper clock sources
  input  wire logic [6:0] upper_tap_in,
  input  wire logic       upper_count_pin_in,
  // Lower outputs
  output logic            lower_divider_out,
  output logic            lower_pwm_out,
  output logic            lower_match_irq_out,
  output logic [7:0]      lower_duty_rd_out,
  output logic [7:0]      lower_count_out,
  // Upper outputs
  output logic            upper_divider_out,
  output logic            upper_pwm_out,
  output logic            upper_match_irq_out,
  output logic [7:0]      upper_duty_rd_out,
  output logic [7:0]      upper_count_out
);

  // ========================================================================
  // Helpers
  function automatic tm_pkg::tm_op_t op_of(input logic [2:0] own,
                                           input logic [2:0] up);
    if (up == `TM_MODE_TIM16) begin
      op_of = tm_pkg::TM_OP_TIM16;
    end else if (up == `TM_MODE_PWM16) begin
      op_of = tm_pkg::TM_OP_PWM16;
    end else if (own == `TM_MODE_PDO) begin
      op_of = tm_pkg::TM_OP_PDO;
    end else if (own == `TM_MODE_PWM8) begin
      op_of = tm_pkg::TM_OP_PWM8;
    end else begin
      op_of = tm_pkg::TM_OP_IDLE;
    end
  endfunction

  function automatic logic is16(input tm_pkg::tm_op_t op);
    is16 = (op == tm_pkg::TM_OP_TIM16) || (op == tm_pkg::TM_OP_PWM16);
  endfunction

  function automatic tm_pkg::tm_byte_t inc8(input tm_pkg::tm_byte_t v);
    inc8 = v + `TM_BYTE_ONE;
  endfunction

  // ========================================================================
  // Input packing, index 0 lower and 1 upper
  logic [1:0]       ctrl_wr;
  logic [1:0]       cmp_wr;
  logic [1:0]       duty_wr;
  logic [1:0]       run_d;
  logic [1:0]       init_d;
  logic [1:0]       tick;
  logic [2:0]       mode_d [2];
  logic [2:0]       sel_d  [2];
  tm_pkg::tm_byte_t cmp_d  [2];
  tm_pkg::tm_byte_t duty_d [2];

  assign ctrl_wr = {upper_ctrl_wr_in, lower_ctrl_wr_in};
  assign cmp_wr  = {upper_compare_wr_in, lower_compare_wr_in};
  assign duty_wr = {upper_duty_wr_in, lower_duty_wr_in};
  assign run_d   = {upper_run_bit_in, lower_run_bit_in};
  assign init_d  = {upper_flop_init_bit_in, lower_flop_init_bit_in};
  assign mode_d[`TM_LO] = lower_mode_in;
  assign mode_d[`TM_HI] = upper_mode_in;
  assign sel_d[`TM_LO]  = lower_clk_sel_in;
  assign sel_d[`TM_HI]  = upper_clk_sel_in;
  assign cmp_d[`TM_LO]  = lower_compare_in;
  assign cmp_d[`TM_HI]  = upper_compare_in;
  assign duty_d[`TM_LO] = lower_duty_in;
  assign duty_d[`TM_HI] = upper_duty_in;

  // ========================================================================
  // Control registers
  logic [2:0] mode_reg  [2];
  logic [2:0] mode_next [2];
  logic [2:0] sel_reg   [2];
  logic [2:0] sel_next  [2];
  logic [1:0] run_reg;
  logic [1:0] run_next;

  always_comb begin
    run_next = run_reg;
    for (int i = 0; i < 2; i++) begin
      mode_next[i] = mode_reg[i];
      sel_next[i]  = sel_reg[i];
      if (ctrl_wr[i]) begin
        mode_next[i] = mode_d[i];
        sel_next[i]  = sel_d[i];
        run_next[i]  = run_d[i];
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      run_reg <= 2'h0;
      for (int i = 0; i < 2; i++) begin
        mode_reg[i] <= 3'h0;
        sel_reg[i]  <= 3'h0;
      end
    end else begin
      run_reg <= run_next;
      for (int i = 0; i < 2; i++) begin
        mode_reg[i] <= mode_next[i];
        sel_reg[i]  <= sel_next[i];
      end
    end
  end

  tm_pkg::tm_op_t op_r   [2];
  tm_pkg::tm_op_t op_n   [2];
  logic [1:0]     run_eff;

  // In 16-bit modes the upper run bit governs both halves
  assign op_r[`TM_LO] = op_of(mode_reg[`TM_LO], mode_reg[`TM_HI]);
  assign op_r[`TM_HI] = op_of(mode_reg[`TM_HI], mode_reg[`TM_HI]);
  assign op_n[`TM_LO] = op_of(mode_next[`TM_LO], mode_next[`TM_HI]);
  assign op_n[`TM_HI] = op_of(mode_next[`TM_HI], mode_next[`TM_HI]);
  assign run_eff[`TM_LO] = is16(op_r[`TM_HI]) ? run_reg[`TM_HI]
                                              : run_reg[`TM_LO];
  assign run_eff[`TM_HI] = run_reg[`TM_HI];

  // ========================================================================
  // Tick sources
  tm_tick_sel u_tick_lo (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .tap_in    (lower_tap_in),
    .pin_in    (lower_count_pin_in),
    .sel_in    (sel_reg[`TM_LO]),
    .tick_out  (tick[`TM_LO])
  );

  tm_tick_sel u_tick_hi (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .tap_in    (upper_tap_in),
    .pin_in    (upper_count_pin_in),
    .sel_in    (sel_reg[`TM_HI]),
    .tick_out  (tick[`TM_HI])
  );

  // ========================================================================
  // Counters, flops, compare and duty stages
  tm_pkg::tm_byte_t cnt_reg  [2];
  tm_pkg::tm_byte_t cnt_next [2];
  tm_pkg::tm_byte_t cmp_reg  [2];
  tm_pkg::tm_byte_t cmp_next [2];
  tm_pkg::tm_byte_t buf_reg  [2];
  tm_pkg::tm_byte_t buf_next [2];
  tm_pkg::tm_byte_t act_reg  [2];
  tm_pkg::tm_byte_t act_next [2];
  tm_pkg::tm_byte_t rd_reg   [2];
  tm_pkg::tm_byte_t rd_next  [2];
  logic [1:0]       flop_reg;
  logic [1:0]       flop_next;
  logic [1:0]       irq_reg;
  logic [1:0]       irq_next;
  logic [1:0]       div_reg;
  logic [1:0]       div_next;
  logic [1:0]       pwm_reg;
  logic [1:0]       pwm_next;

  always_comb begin
    logic [15:0] c16;
    logic [15:0] i16;
    c16 = {cnt_reg[`TM_HI], cnt_reg[`TM_LO]};
    i16 = c16 + `TM_WORD_ONE;
    flop_next = flop_reg;
    irq_next  = 2'h0;
    for (int i = 0; i < 2; i++) begin
      cnt_next[i] = cnt_reg[i];
      cmp_next[i] = cmp_reg[i];
      buf_next[i] = buf_reg[i];
      act_next[i] = act_reg[i];
      if (cmp_wr[i]) begin
        cmp_next[i] = cmp_d[i];
      end
      if (duty_wr[i]) begin
        buf_next[i] = duty_d[i];
        if (!run_eff[i]) begin
          act_next[i] = duty_d[i];
        end
      end
      if (!run_eff[i]) begin
        cnt_next[i] = `TM_BYTE_ZERO;
      end else if (tick[i]) begin
        case (op_r[i])
          tm_pkg::TM_OP_PDO: begin
            if (inc8(cnt_reg[i]) == cmp_reg[i]) begin
              cnt_next[i]  = `TM_BYTE_ZERO;
              flop_next[i] = ~flop_reg[i];
              irq_next[i]  = 1'b1;
            end else begin
              cnt_next[i] = inc8(cnt_reg[i]);
            end
          end
          tm_pkg::TM_OP_PWM8: begin
            if (cnt_reg[i] == `TM_BYTE_MAX) begin
              cnt_next[i]  = `TM_BYTE_ZERO;
              flop_next[i] = ~flop_reg[i];
              irq_next[i]  = 1'b1;
              // A write in this same cycle lands in the buffer only
              act_next[i]  = buf_reg[i];
            end else begin
              cnt_next[i] = inc8(cnt_reg[i]);
              if (inc8(cnt_reg[i]) == act_reg[i]) begin
                flop_next[i] = ~flop_reg[i];
              end
            end
          end
          default: begin
          end
        endcase
      end
    end
    // Upper half advances only on the lower carry
    if (run_reg[`TM_HI] && tick[`TM_LO]) begin
      case (op_r[`TM_HI])
        tm_pkg::TM_OP_TIM16: begin
          if (i16 == {cmp_reg[`TM_HI], cmp_reg[`TM_LO]}) begin
            cnt_next[`TM_HI] = `TM_BYTE_ZERO;
            cnt_next[`TM_LO] = `TM_BYTE_ZERO;
            irq_next[`TM_HI] = 1'b1;
          end else begin
            {cnt_next[`TM_HI], cnt_next[`TM_LO]} = i16;
          end
        end
        tm_pkg::TM_OP_PWM16: begin
          if (c16 == `TM_WORD_MAX) begin
            {cnt_next[`TM_HI], cnt_next[`TM_LO]} = `TM_WORD_ZERO;
            flop_next[`TM_HI] = ~flop_reg[`TM_HI];
            irq_next[`TM_HI]  = 1'b1;
            act_next[`TM_HI]  = buf_reg[`TM_HI];
            act_next[`TM_LO]  = buf_reg[`TM_LO];
          end else begin
            {cnt_next[`TM_HI], cnt_next[`TM_LO]} = i16;
            if (i16 == {act_reg[`TM_HI], act_reg[`TM_LO]}) begin
              flop_next[`TM_HI] = ~flop_reg[`TM_HI];
            end
          end
        end
        default: begin
        end
      endcase
    end
    for (int i = 0; i < 2; i++) begin
      // A stopping write leaves the flop alone, so the pin level stays
      if (ctrl_wr[i] && !run_reg[i]) begin
        flop_next[i] = init_d[i];
      end
      div_next[i] = (op_n[i] == tm_pkg::TM_OP_PDO) ? ~flop_next[i]
                                                   : `TM_PIN_IDLE;
      if ((op_n[i] == tm_pkg::TM_OP_PWM8) ||
          (i == `TM_HI && op_n[i] == tm_pkg::TM_OP_PWM16)) begin
        pwm_next[i] = ~flop_next[i];
      end else begin
        pwm_next[i] = `TM_PIN_IDLE;
      end
      if ((op_n[i] == tm_pkg::TM_OP_PWM8) ||
          (op_n[i] == tm_pkg::TM_OP_PWM16)) begin
        rd_next[i] = act_next[i];
      end else begin
        rd_next[i] = buf_next[i];
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      flop_reg <= {2{`TM_FLOP_RST}};
      irq_reg  <= 2'h0;
      div_reg  <= {2{`TM_PIN_IDLE}};
      pwm_reg  <= {2{`TM_PIN_IDLE}};
      for (int i = 0; i < 2; i++) begin
        cnt_reg[i] <= `TM_BYTE_ZERO;
        cmp_reg[i] <= `TM_BYTE_ZERO;
        buf_reg[i] <= `TM_BYTE_ZERO;
        act_reg[i] <= `TM_BYTE_ZERO;
        rd_reg[i]  <= `TM_BYTE_ZERO;
      end
    end else begin
      flop_reg <= flop_next;
      irq_reg  <= irq_next;
      div_reg  <= div_next;
      pwm_reg  <= pwm_next;
      for (int i = 0; i < 2; i++) begin
        cnt_reg[i] <= cnt_next[i];
        cmp_reg[i] <= cmp_next[i];
        buf_reg[i] <= buf_next[i];
        act_reg[i] <= act_next[i];
        rd_reg[i]  <= rd_next[i];
      end
    end
  end

  // ========================================================================
  // Outputs
  assign lower_divider_out   = div_reg[`TM_LO];
  assign lower_pwm_out       = pwm_reg[`TM_LO];
  assign lower_match_irq_out = irq_reg[`TM_LO];
  assign lower_duty_rd_out   = rd_reg[`TM_LO];
  assign lower_count_out     = cnt_reg[`TM_LO];
  assign upper_divider_out   = div_reg[`TM_HI];
  assign upper_pwm_out       = pwm_reg[`TM_HI];
  assign upper_match_irq_out = irq_reg[`TM_HI];
  assign upper_duty_rd_out   = rd_reg[`TM_HI];
  assign upper_count_out     = cnt_reg[`TM_HI];

  // ========================================================================
  // Assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  a_pdo_pin_inv: assert property (
    op_r[`TM_LO] == tm_pkg::TM_OP_PDO |-> div_reg[`TM_LO] == !flop_reg[`TM_LO])
    else $error("divider pin not inverse of flop");
  a_pdo_toggle: assert property (
    (irq_reg[`TM_LO] && op_r[`TM_LO] == tm_pkg::TM_OP_PDO &&
     !$past(ctrl_wr[`TM_LO])) |->
    (flop_reg[`TM_LO] != $past(flop_reg[`TM_LO]) &&
     cnt_reg[`TM_LO] == `TM_BYTE_ZERO))
    else $error("divider match without toggle and clear");
  a_flop_load: assert property (
    ($past(ctrl_wr[`TM_HI]) && !$past(run_reg[`TM_HI])) |->
    flop_reg[`TM_HI] == $past(init_d[`TM_HI]))
    else $error("flop not loaded from init bit");
  a_stop_hold: assert property (
    (!run_reg[`TM_LO] && !$past(run_reg[`TM_LO]) &&
     !$past(ctrl_wr[`TM_LO]) && !is16(op_r[`TM_HI])) |-> $stable(flop_reg[`TM_LO]))
    else $error("stopped flop changed");
  a_pwm_buffer: assert property (
    (op_r[`TM_LO] == tm_pkg::TM_OP_PWM8 && run_reg[`TM_LO] &&
     $past(run_reg[`TM_LO]) && $changed(act_reg[`TM_LO])) |-> irq_reg[`TM_LO])
    else $error("active duty changed without irq");
  a_stop_xfer: assert property (
    ($past(op_r[`TM_LO]) == tm_pkg::TM_OP_PWM8 && !$past(run_reg[`TM_LO]) &&
     $past(duty_wr[`TM_LO])) |-> act_reg[`TM_LO] == $past(duty_d[`TM_LO]))
    else $error("stopped duty write not transferred");
  a_read_active: assert property (
    op_r[`TM_HI] == tm_pkg::TM_OP_PWM8 |-> rd_reg[`TM_HI] == act_reg[`TM_HI])
    else $error("duty read not active stage");
  a_pwm8_ovf: assert property (
    (irq_reg[`TM_LO] && $past(op_r[`TM_LO]) == tm_pkg::TM_OP_PWM8) |->
    ($past(cnt_reg[`TM_LO]) == `TM_BYTE_MAX && cnt_reg[`TM_LO] == `TM_BYTE_ZERO))
    else $error("pwm irq not at overflow");
  a_t16_clear: assert property (
    (irq_reg[`TM_HI] && $past(op_r[`TM_HI]) == tm_pkg::TM_OP_TIM16) |->
    ({cnt_reg[`TM_HI], cnt_reg[`TM_LO]} == `TM_WORD_ZERO && $past(tick[`TM_LO])))
    else $error("16-bit match did not clear");
  a_cascade: assert property (
    (is16(op_r[`TM_HI]) && $changed(cnt_reg[`TM_HI]) &&
     cnt_reg[`TM_HI] != `TM_BYTE_ZERO) |-> $past(cnt_reg[`TM_LO]) == `TM_BYTE_MAX)
    else $error("upper counted without lower carry");
  a_pwm16_ovf: assert property (
    (irq_reg[`TM_HI] && $past(op_r[`TM_HI]) == tm_pkg::TM_OP_PWM16) |->
    $past({cnt_reg[`TM_HI], cnt_reg[`TM_LO]}) == `TM_WORD_MAX)
    else $error("16-bit pwm irq not at overflow");
  a_run_clear: assert property (
    !run_reg[`TM_HI] |=> cnt_reg[`TM_HI] == `TM_BYTE_ZERO)
    else $error("stopped counter not cleared");

endmodule
`default_nettype wire

/* dv/tm_cascade_timer_tb.sv */
// Self-checking bench for the cascadable timer: reset, a mode table, then
// stop, buffering and 16-bit cases by hand.
// Assumes every prescaler tap is held high, so each cycle is a tick.
`timescale 1ns/1ps
`default_nettype none
`include "tm_defines.svh"

module tm_cascade_timer_tb;
  // ==========================================================================
  // Signals
  typedef struct {
    logic [2:0] m;
    logic [7:0] v;
    int         per;
    int         hi;
  } tm_row_t;
  logic            clk_in;
  logic            arst_n_in;
  logic [1:0]      ctrl_wr;
  logic [1:0]      run;
  logic [1:0]      init;
  logic [1:0]      cmp_wr;
  logic [1:0]      duty_wr;
  logic [1:0]      pin;
  logic [2:0]      mode [2];
  logic [2:0]      sel  [2];
  logic [7:0]      cmp  [2];
  logic [7:0]      duty [2];
  logic [6:0]      tap;
  wire logic [1:0] div_o;
  wire logic [1:0] pwm_o;
  wire logic [1:0] irq_o;
  wire logic [7:0] drd  [2];
  wire logic [7:0] cnt  [2];
  int              fail_count;
  int              num_checks;
  int              n;
  int              h;
  int              ev;
  logic            lv;
  // Pin high counts are over two periods, so register lag cancels out
  tm_row_t rows [7] = '{
    '{`TM_MODE_PDO, 8'h02, 2, 2}, '{`TM_MODE_PDO, 8'h03, 3, 3},
    '{`TM_MODE_PDO, 8'h0a, 10, 10}, '{`TM_MODE_PDO, 8'hff, 255, 255},
    '{`TM_MODE_PWM8, 8'h02, 256, 4}, '{`TM_MODE_PWM8, 8'h80, 256, 256},
    '{`TM_MODE_PWM8, 8'hfe, 256, 508}};

  tm_cascade_timer uut (
    .clk_in                 (clk_in),
    .arst_n_in              (arst_n_in),
    .lower_ctrl_wr_in       (ctrl_wr[0]),
    .lower_mode_in          (mode[0]),
    .lower_clk_sel_in       (sel[0]),
    .lower_run_bit_in       (run[0]),
    .lower_flop_init_bit_in (init[0]),
    .lower_compare_wr_in    (cmp_wr[0]),
    .lower_compare_in       (cmp[0]),
    .lower_duty_wr_in       (duty_wr[0]),
    .lower_duty_in          (duty[0]),
    .lower_tap_in           (tap),
    .lower_count_pin_in     (pin[0]),
    .upper_ctrl_wr_in       (ctrl_wr[1]),
    .upper_mode_in          (mode[1]),
    .upper_clk_sel_in       (sel[1]),
    .upper_run_bit_in       (run[1]),
    .upper_flop_init_bit_in (init[1]),
    .upper_compare_wr_in    (cmp_wr[1]),
    .upper_compare_in       (cmp[1]),
    .upper_duty_wr_in       (duty_wr[1]),
    .upper_duty_in          (duty[1]),
    .upper_tap_in           (tap),
    .upper_count_pin_in     (pin[1]),
    .lower_divider_out      (div_o[0]),
    .lower_pwm_out          (pwm_o[0]),
    .lower_match_irq_out    (irq_o[0]),
    .lower_duty_rd_out      (drd[0]),
    .lower_count_out        (cnt[0]),
    .upper_divider_out      (div_o[1]),
    .upper_pwm_out          (pwm_o[1]),
    .upper_match_irq_out    (irq_o[1]),
    .upper_duty_rd_out      (drd[1]),
    .upper_count_out        (cnt[1])
  );

  // ==========================================================================
  // Clock, irq tally and watchdog
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (irq_o[1] === 1'b1) ev <= ev + 1;
  end
  initial begin
    repeat (100000) @(posedge clk_in);
    fail_count++;
    complete_run();
  end

  // ==========================================================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask
  // Control write: one-cycle strobe with its fields
  task automatic ctl(input int c, input logic [2:0] m, s, input logic r, f);
    @(posedge clk_in);
    ctrl_wr[c] <= 1'b1;
    mode[c] <= m;
    sel[c] <= s;
    run[c] <= r;
    init[c] <= f;
    @(posedge clk_in);
    ctrl_wr[c] <= 1'b0;
  endtask
  // Compare write when d is 0, duty write when d is 1
  task automatic wr(input int c, input logic d, input logic [7:0] v);
    @(posedge clk_in);
    cmp[c] <= v;
    duty[c] <= v;
    cmp_wr[c] <= ~d;
    duty_wr[c] <= d;
    @(posedge clk_in);
    cmp_wr[c] <= 1'b0;
    duty_wr[c] <= 1'b0;
    // Let the write edge settle before anyone reads back
    #1;
  endtask
  task automatic wirq(input int c, input int lim, output int k);
    k = 0;
    do begin
      cyc(1);
      k++;
    end while (irq_o[c] !== 1'b1 && k < lim);
  endtask
  task automatic fall(input int k);
    repeat (k) begin
      @(posedge clk_in);
      pin[0] <= 1'b0;
      repeat (3) @(posedge clk_in);
      pin[0] <= 1'b1;
      repeat (3) @(posedge clk_in);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    arst_n_in = 1'b0;
    {ctrl_wr, run, init, cmp_wr, duty_wr} = '0;
    pin = 2'b11;
    tap = 7'h7f;
    ev = 0;
    fail_count = 0;
    num_checks = 0;
    for (int c = 0; c < 2; c++) begin
      mode[c] = 3'h0;
      sel[c] = 3'h0;
      cmp[c] = 8'h00;
      duty[c] = 8'h00;
    end
    cyc(16);
    chk("reset pins", 4'hf, {div_o, pwm_o});
    chk("reset irq", 2'b00, irq_o);
    @(posedge clk_in);
    arst_n_in <= 1'b1;
    // Table: stop, preset flop 0 after the stop, load value, start
    for (int c = 0; c < 2; c++) begin
      foreach (rows[i]) begin
        ctl(c, rows[i].m, 3'h0, 1'b0, 1'b0);
        wr(c, rows[i].m == `TM_MODE_PWM8, rows[i].v);
        if (rows[i].m == `TM_MODE_PWM8) chk("duty rd", rows[i].v, drd[c]);
        ctl(c, rows[i].m, 3'h0, 1'b1, 1'b0);
        wirq(c, 600, n);
        wirq(c, 600, n);
        chk("period", rows[i].per, n);
        h = 0;
        repeat (2 * rows[i].per) begin
          cyc(1);
          lv = (rows[i].m == `TM_MODE_PDO) ? div_o[c] : pwm_o[c];
          h += (lv === 1'b1) ? 1 : 0;
        end
        chk("pin high", rows[i].hi, h);
        lv = (rows[i].m == `TM_MODE_PDO) ? pwm_o[c] : div_o[c];
        chk("idle pin", 1'b1, lv);
        ctl(c, rows[i].m, 3'h0, 1'b0, 1'b0);
      end
    end
    // Stopping write carries init, which must not move the pin
    ctl(0, `TM_MODE_PDO, 3'h0, 1'b0, 1'b0);
    wr(0, 1'b0, 8'hff);
    ctl(0, `TM_MODE_PDO, 3'h0, 1'b1, 1'b0);
    cyc(2);
    wr(0, 1'b0, 8'h0a);
    wirq(0, 20, n);
    chk("early match", 1'b1, n <= 10);
    cyc(1);
    lv = div_o[0];
    ctl(0, `TM_MODE_PDO, 3'h0, 1'b0, lv);
    cyc(3);
    chk("held div", lv, div_o[0]);
    chk("stop count", 8'h00, cnt[0]);
    ctl(0, `TM_MODE_PDO, 3'h0, 1'b0, lv);
    cyc(1);
    chk("init div", !lv, div_o[0]);
    // Duty write while running waits for the overflow irq
    ctl(0, `TM_MODE_PWM8, 3'h0, 1'b0, 1'b0);
    wr(0, 1'b1, 8'h40);
    ctl(0, `TM_MODE_PWM8, 3'h0, 1'b1, 1'b0);
    wirq(0, 300, n);
    wr(0, 1'b1, 8'h80);
    chk("old duty", 8'h40, drd[0]);
    wirq(0, 300, n);
    cyc(1);
    chk("new duty", 8'h80, drd[0]);
    lv = pwm_o[0];
    ctl(0, `TM_MODE_PWM8, 3'h0, 1'b0, lv);
    cyc(3);
    chk("held pwm", lv, pwm_o[0]);
    ctl(0, `TM_MODE_PWM8, 3'h0, 1'b0, lv);
    cyc(1);
    chk("init pwm", !lv, pwm_o[0]);
    // 16-bit timer, compare 0x0104, upper byte written first
    ctl(0, `TM_MODE_LOW16, 3'h0, 1'b0, 1'b0);
    ctl(1, `TM_MODE_TIM16, 3'h0, 1'b0, 1'b0);
    wr(1, 1'b0, 8'h01);
    wr(0, 1'b0, 8'h04);
    ctl(1, `TM_MODE_TIM16, 3'h0, 1'b1, 1'b0);
    wirq(1, 600, n);
    wirq(1, 600, n);
    chk("timer16 period", 260, n);
    // 257 ticks after the match the count is 0x0101
    cyc(257);
    chk("cascade hi", 8'h01, cnt[1]);
    ctl(1, `TM_MODE_TIM16, 3'h0, 1'b0, 1'b0);
    // Event counter: three falling edges, pin low three cycles and high four between edges
    ctl(0, `TM_MODE_LOW16, `TM_SEL_PIN, 1'b0, 1'b0);
    wr(0, 1'b0, 8'h03);
    wr(1, 1'b0, 8'h00);
    ctl(1, `TM_MODE_TIM16, 3'h0, 1'b1, 1'b0);
    h = ev;
    fall(2);
    chk("event early", h, ev);
    fall(1);
    chk("event match", h + 1, ev);
    ctl(1, `TM_MODE_TIM16, 3'h0, 1'b0, 1'b0);
    // 16-bit PWM, duty 0x0002, lower byte written first
    ctl(0, `TM_MODE_LOW16, 3'h0, 1'b0, 1'b0);
    ctl(1, `TM_MODE_PWM16, 3'h0, 1'b0, 1'b0);
    wr(0, 1'b1, 8'h02);
    wr(1, 1'b1, 8'h00);
    ctl(1, `TM_MODE_PWM16, 3'h0, 1'b1, 1'b0);
    cyc(6);
    chk("pwm16 match", 1'b0, pwm_o[1]);
    wirq(1, 70000, n);
    chk("pwm16 period", 1'b1, n >= 65528 && n <= 65536);
    // One tick after the wrap the pin is high, ahead of the duty match
    cyc(1);
    chk("pwm16 wrap", 1'b1, pwm_o[1]);
    complete_run();
  end
endmodule
`default_nettype wire
